/* File: pio_parallel_io_ports.sv */
`timescale 1ns/1ps
module pio_parallel_io_ports (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Processor bus
    input wire logic [31:0] bus_addr_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [31:0] bus_wdata_i,
    output logic [31:0] bus_rdata_o,
    output logic bus_rvalid_o,
    // Lights, switches, buttons
    output logic [7:0] green_lights_o,
    input wire logic [3:0] dip_toggles_i,
    input wire logic [1:0] button_i,
    // Header a
    input wire logic [31:0] header_a_i,
    output logic [31:0] header_a_o,
    output logic [31:0] header_a_oe_o,
    // Header b
    input wire logic [31:0] header_b_i,
    output logic [31:0] header_b_o,
    output logic [31:0] header_b_oe_o,
    // Header c
    input wire logic [12:0] header_c_i,
    output logic [12:0] header_c_o,
    output logic [12:0] header_c_oe_o,
    input wire logic [2:0] header_c_in_i
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic hit(input logic [31:0] addr, input logic [31:0] reg_addr);
        return addr[31:2] == reg_addr[31:2];
    endfunction

    function automatic logic [31:0] mix(input logic [31:0] pin, input logic [31:0] out,
                                        input logic [31:0] dir);
        return (pin & ~dir) | (out & dir);
    endfunction

    pio_pkg::pio_state_s st_ff;
    pio_pkg::pio_state_s nxt_st;
    logic [pio_pkg::HDR_PORTS-1:0][31:0] hdr_pin;
    logic [pio_pkg::HDR_PORTS-1:0][31:0] hdr_base;

    assign hdr_pin[0] = header_a_i;
    assign hdr_pin[1] = header_b_i;
    assign hdr_base[0] = pio_pkg::HDR_A_BASE;
    assign hdr_base[1] = pio_pkg::HDR_B_BASE;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rvalid = bus_rd_i;
        nxt_st.rdata = pio_pkg::RDATA_RST;
        if (bus_wr_i) begin
            if (hit(bus_addr_i, pio_pkg::LIGHT_BASE)) begin
                nxt_st.light = bus_wdata_i[pio_pkg::LIGHT_W-1:0];
            end
            if (hit(bus_addr_i, pio_pkg::BUTTON_AUX_A)) begin
                nxt_st.aux_a = bus_wdata_i[pio_pkg::BUTTON_W-1:0];
            end
            if (hit(bus_addr_i, pio_pkg::BUTTON_AUX_B)) begin
                nxt_st.aux_b = bus_wdata_i[pio_pkg::BUTTON_W-1:0];
            end
            for (int p = 0; p < pio_pkg::HDR_PORTS; p++) begin
                if (hit(bus_addr_i, hdr_base[p])) begin
                    nxt_st.hdr_out[p] = bus_wdata_i;
                end
                if (hit(bus_addr_i, hdr_base[p] + pio_pkg::DIR_OFF)) begin
                    nxt_st.hdr_dir[p] = bus_wdata_i;
                end
            end
            if (hit(bus_addr_i, pio_pkg::HDR_C_BASE)) begin
                nxt_st.c_out = bus_wdata_i[pio_pkg::HDR_C_W-1:0];
            end
            if (hit(bus_addr_i, pio_pkg::HDR_C_BASE + pio_pkg::DIR_OFF)) begin
                nxt_st.c_dir = bus_wdata_i[pio_pkg::HDR_C_W-1:0];
            end
        end
        if (bus_rd_i) begin
            if (hit(bus_addr_i, pio_pkg::LIGHT_BASE)) begin
                nxt_st.rdata = 32'(st_ff.light);
            end
            if (hit(bus_addr_i, pio_pkg::SWITCH_BASE)) begin
                nxt_st.rdata = 32'(dip_toggles_i);
            end
            if (hit(bus_addr_i, pio_pkg::BUTTON_BASE)) begin
                nxt_st.rdata = 32'(button_i);
            end
            if (hit(bus_addr_i, pio_pkg::BUTTON_AUX_A)) begin
                nxt_st.rdata = 32'(st_ff.aux_a);
            end
            if (hit(bus_addr_i, pio_pkg::BUTTON_AUX_B)) begin
                nxt_st.rdata = 32'(st_ff.aux_b);
            end
            for (int p = 0; p < pio_pkg::HDR_PORTS; p++) begin
                if (hit(bus_addr_i, hdr_base[p])) begin
                    nxt_st.rdata = mix(hdr_pin[p], st_ff.hdr_out[p], st_ff.hdr_dir[p]);
                end
                if (hit(bus_addr_i, hdr_base[p] + pio_pkg::DIR_OFF)) begin
                    nxt_st.rdata = st_ff.hdr_dir[p];
                end
            end
            if (hit(bus_addr_i, pio_pkg::HDR_C_BASE)) begin
                nxt_st.rdata = mix(32'(header_c_i), 32'(st_ff.c_out), 32'(st_ff.c_dir));
            end
            if (hit(bus_addr_i, pio_pkg::HDR_C_BASE + pio_pkg::DIR_OFF)) begin
                nxt_st.rdata = 32'(st_ff.c_dir);
            end
            if (hit(bus_addr_i, pio_pkg::HDR_C_IN_BASE)) begin
                nxt_st.rdata = 32'(header_c_in_i);
            end
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_ff.light <= pio_pkg::LIGHT_RST;
            st_ff.aux_a <= pio_pkg::AUX_RST;
            st_ff.aux_b <= pio_pkg::AUX_RST;
            for (int p = 0; p < pio_pkg::HDR_PORTS; p++) begin
                st_ff.hdr_out[p] <= pio_pkg::HDR_RST;
                st_ff.hdr_dir[p] <= pio_pkg::HDR_RST;
            end
            st_ff.c_out <= pio_pkg::HDR_C_RST;
            st_ff.c_dir <= pio_pkg::HDR_C_RST;
            st_ff.rdata <= pio_pkg::RDATA_RST;
            st_ff.rvalid <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign bus_rdata_o = st_ff.rdata;
    assign bus_rvalid_o = st_ff.rvalid;
    assign green_lights_o = st_ff.light;
    assign header_a_o = st_ff.hdr_out[0];
    assign header_a_oe_o = st_ff.hdr_dir[0];
    assign header_b_o = st_ff.hdr_out[1];
    assign header_b_oe_o = st_ff.hdr_dir[1];
    assign header_c_o = st_ff.c_out;
    assign header_c_oe_o = st_ff.c_dir;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_wr(logic [31:0] a);
        bus_wr_i && hit(bus_addr_i, a);
    endsequence

    sequence s_rd(logic [31:0] a);
        bus_rd_i && !bus_wr_i && hit(bus_addr_i, a);
    endsequence

    property p_light_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_wr(pio_pkg::LIGHT_BASE) |=> green_lights_o == $past(bus_wdata_i[7:0]);
    endproperty
    a_light_write: assert property (p_light_write) else $error("light write lost");

    property p_light_readback;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_wr(pio_pkg::LIGHT_BASE) ##1 s_rd(pio_pkg::LIGHT_BASE)
            |=> bus_rdata_o == {24'h000000, $past(bus_wdata_i[7:0], 2)};
    endproperty
    a_light_readback: assert property (p_light_readback) else $error("light readback");

    property p_reset_clear;
        @(posedge clk_i)
        !rst_n_i |=> header_a_oe_o == 32'h0 && header_b_oe_o == 32'h0 &&
            header_c_oe_o == 13'h0 && green_lights_o == 8'h00 && header_a_o == 32'h0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset not clear");

    property p_dir_a;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_wr(pio_pkg::HDR_A_BASE + pio_pkg::DIR_OFF) |=> header_a_oe_o == $past(bus_wdata_i);
    endproperty
    a_dir_a: assert property (p_dir_a) else $error("direction a not written");

    property p_dir_c;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_wr(pio_pkg::HDR_C_BASE + pio_pkg::DIR_OFF) |=> header_c_oe_o == $past(bus_wdata_i[12:0]);
    endproperty
    a_dir_c: assert property (p_dir_c) else $error("direction c not written");

    property p_data_b;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_wr(pio_pkg::HDR_B_BASE) |=> header_b_o == $past(bus_wdata_i) && $stable(header_a_o);
    endproperty
    a_data_b: assert property (p_data_b) else $error("header b data wrong");

    property p_switch_read;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_rd(pio_pkg::SWITCH_BASE) |=> bus_rvalid_o &&
            bus_rdata_o == {28'h0, $past(dip_toggles_i)};
    endproperty
    a_switch_read: assert property (p_switch_read) else $error("switch read wrong");

    property p_button_read;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_rd(pio_pkg::BUTTON_BASE) |=> bus_rdata_o == {30'h0, $past(button_i)};
    endproperty
    a_button_read: assert property (p_button_read) else $error("button read wrong");

    property p_mix_a;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_rd(pio_pkg::HDR_A_BASE) |=> bus_rdata_o ==
            (($past(header_a_i) & ~$past(header_a_oe_o)) |
            ($past(header_a_o) & $past(header_a_oe_o)));
    endproperty
    a_mix_a: assert property (p_mix_a) else $error("header a read mix wrong");

    property p_input_only;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_rd(pio_pkg::HDR_C_IN_BASE) |=> bus_rdata_o == {29'h0, $past(header_c_in_i)};
    endproperty
    a_input_only: assert property (p_input_only) else $error("input port read wrong");

    property p_aux_a;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_wr(pio_pkg::BUTTON_AUX_A) ##1 s_rd(pio_pkg::BUTTON_AUX_A)
            |=> bus_rdata_o == {30'h0, $past(bus_wdata_i[1:0], 2)};
    endproperty
    a_aux_a: assert property (p_aux_a) else $error("aux a readback bad");

    property p_unused_zero;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_rd(pio_pkg::HDR_A_BASE + pio_pkg::AUX_B_OFF) |=> bus_rvalid_o && bus_rdata_o == 32'h0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused word not zero");

    property p_rvalid_follow;
        @(posedge clk_i) disable iff (!rst_n_i)
        bus_rd_i |=> bus_rvalid_o;
    endproperty
    a_rvalid_follow: assert property (p_rvalid_follow) else $error("no read answer");

    property p_idle_quiet;
        @(posedge clk_i) disable iff (!rst_n_i)
        !bus_rd_i |=> !bus_rvalid_o && bus_rdata_o == 32'h0;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("idle read data");

    property p_dir_b;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_wr(pio_pkg::HDR_B_BASE + pio_pkg::DIR_OFF) |=> header_b_oe_o == $past(bus_wdata_i);
    endproperty
    a_dir_b: assert property (p_dir_b) else $error("direction b not written");

    property p_data_a;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_wr(pio_pkg::HDR_A_BASE) |=> header_a_o == $past(bus_wdata_i) && $stable(header_b_o);
    endproperty
    a_data_a: assert property (p_data_a) else $error("header a data wrong");

    property p_data_c;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_wr(pio_pkg::HDR_C_BASE) |=> header_c_o == $past(bus_wdata_i[12:0]);
    endproperty
    a_data_c: assert property (p_data_c) else $error("header c data wrong");

    property p_aux_b;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_wr(pio_pkg::BUTTON_AUX_B) ##1 s_rd(pio_pkg::BUTTON_AUX_B)
            |=> bus_rdata_o == {30'h0, $past(bus_wdata_i[1:0], 2)};
    endproperty
    a_aux_b: assert property (p_aux_b) else $error("aux b readback bad");

    property p_ro_ignored;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_wr(pio_pkg::SWITCH_BASE) |=> $stable(green_lights_o) && $stable(header_a_o) &&
            $stable(header_c_oe_o);
    endproperty
    a_ro_ignored: assert property (p_ro_ignored) else $error("read-only write landed");

    property p_dir_c_read;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_rd(pio_pkg::HDR_C_BASE + pio_pkg::DIR_OFF)
            |=> bus_rdata_o == {19'h0, $past(header_c_oe_o)};
    endproperty
    a_dir_c_read: assert property (p_dir_c_read) else $error("dir c readback bad");

    property p_dir_b_read;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_rd(pio_pkg::HDR_B_BASE + pio_pkg::DIR_OFF) |=> bus_rdata_o == $past(header_b_oe_o);
    endproperty
    a_dir_b_read: assert property (p_dir_b_read) else $error("dir b readback bad");

    property p_mix_c;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_rd(pio_pkg::HDR_C_BASE) |=> bus_rdata_o == {19'h0,
            ($past(header_c_i) & ~$past(header_c_oe_o)) |
            ($past(header_c_o) & $past(header_c_oe_o))};
    endproperty
    a_mix_c: assert property (p_mix_c) else $error("header c read mix wrong");

    property p_rw_same;
        @(posedge clk_i) disable iff (!rst_n_i)
        bus_rd_i && bus_wr_i && hit(bus_addr_i, pio_pkg::LIGHT_BASE)
            |=> bus_rdata_o == {24'h0, $past(green_lights_o)};
    endproperty
    a_rw_same: assert property (p_rw_same) else $error("same-cycle read not old");

    property p_reset_rd;
        @(posedge clk_i)
        !rst_n_i |=> !bus_rvalid_o && bus_rdata_o == 32'h0 && header_b_o == 32'h0;
    endproperty
    a_reset_rd: assert property (p_reset_rd) else $error("reset left read data");

endmodule

/* File: pio_parallel_io_ports_bench.sv */
`timescale 1ns/1ps
module pio_parallel_io_ports_bench;
    logic clk_i, rst_n_i, bus_wr_i, bus_rd_i, bus_rvalid_o;
    logic [31:0] bus_addr_i, bus_wdata_i, bus_rdata_o;
    logic [7:0] green_lights_o;
    logic [3:0] dip_toggles_i;
    logic [1:0] button_i;
    logic [2:0] header_c_in_i;
    logic [31:0] header_a_i, header_a_o, header_a_oe_o, ext_a;
    logic [31:0] header_b_i, header_b_o, header_b_oe_o, ext_b;
    logic [12:0] header_c_i, header_c_o, header_c_oe_o, ext_c;
    logic [31:0] base, m, od, dr, pin, o, e, d;
    integer seed, num_errors, checks, cyc;

    // ----------------------------------------
    // Design and board
    // ----------------------------------------
    pio_parallel_io_ports u_pio_parallel_io_ports (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
        .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .bus_rvalid_o(bus_rvalid_o),
        .green_lights_o(green_lights_o), .dip_toggles_i(dip_toggles_i), .button_i(button_i),
        .header_a_i(header_a_i), .header_a_o(header_a_o), .header_a_oe_o(header_a_oe_o),
        .header_b_i(header_b_i), .header_b_o(header_b_o), .header_b_oe_o(header_b_oe_o),
        .header_c_i(header_c_i), .header_c_o(header_c_o), .header_c_oe_o(header_c_oe_o),
        .header_c_in_i(header_c_in_i));
    pio_pin_model #(.W(32)) u_pin_a (.out_i(header_a_o), .oe_i(header_a_oe_o),
        .ext_i(ext_a), .pin_o(header_a_i));
    pio_pin_model #(.W(32)) u_pin_b (.out_i(header_b_o), .oe_i(header_b_oe_o),
        .ext_i(ext_b), .pin_o(header_b_i));
    pio_pin_model #(.W(13)) u_pin_c (.out_i(header_c_o), .oe_i(header_c_oe_o),
        .ext_i(ext_c), .pin_o(header_c_i));

    // ----------------------------------------
    // Clock, timeout, helpers
    // ----------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            stop_test();
        end
    end

    function automatic logic [31:0] mix(input logic [31:0] p, input logic [31:0] q,
                                        input logic [31:0] r);
        return (p & ~r) | (q & r);
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(negedge clk_i);
        bus_addr_i = a;
        bus_wdata_i = v;
        bus_wr_i = 1'b1;
        @(negedge clk_i);
        bus_wr_i = 1'b0;
    endtask

    task automatic rc(input logic [31:0] a, input logic [31:0] exp);
        @(negedge clk_i);
        bus_addr_i = a;
        bus_rd_i = 1'b1;
        @(posedge clk_i);
        #1;
        check("rvalid", {31'h0, bus_rvalid_o}, 32'h1);
        check("rdata", bus_rdata_o, exp);
        @(negedge clk_i);
        bus_rd_i = 1'b0;
    endtask

    task automatic wrc(input logic [31:0] a, input logic [31:0] v, input logic [31:0] exp);
        @(negedge clk_i);
        bus_addr_i = a;
        bus_wdata_i = v;
        bus_wr_i = 1'b1;
        @(negedge clk_i);
        bus_wr_i = 1'b0;
        bus_rd_i = 1'b1;
        @(posedge clk_i);
        #1;
        check("wr_rd", bus_rdata_o, exp);
        @(negedge clk_i);
        bus_rd_i = 1'b0;
    endtask

    task automatic wrd(input logic [31:0] a, input logic [31:0] v, input logic [31:0] exp);
        @(negedge clk_i);
        bus_addr_i = a;
        bus_wdata_i = v;
        bus_wr_i = 1'b1;
        bus_rd_i = 1'b1;
        @(posedge clk_i);
        #1;
        check("rd_old", bus_rdata_o, exp);
        @(negedge clk_i);
        bus_wr_i = 1'b0;
        bus_rd_i = 1'b0;
    endtask

    task automatic stop_test();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 32'h7433;
        num_errors = 0;
        checks = 0;
        cyc = 0;
        rst_n_i = 1'b0;
        {bus_wr_i, bus_rd_i, bus_addr_i, bus_wdata_i} = 66'h0;
        {dip_toggles_i, button_i, header_c_in_i, ext_a, ext_b, ext_c} = 86'h0;
        repeat (10) @(negedge clk_i);
        rst_n_i = 1'b1;
        check("lights", {24'h0, green_lights_o}, 32'h0);
        check("oe", header_a_oe_o | header_b_oe_o | {19'h0, header_c_oe_o}, 32'h0);
        check("outs", header_a_o | header_b_o | {19'h0, header_c_o}, 32'h0);
        for (int i = 0; i < 12; i++) begin
            d = $random(seed);
            wr(pio_pkg::LIGHT_BASE, d);
            check("lights", {24'h0, green_lights_o}, {24'h0, d[7:0]});
            rc(pio_pkg::LIGHT_BASE, {24'h0, d[7:0]});
            wrd(pio_pkg::LIGHT_BASE, ~d, {24'h0, d[7:0]});
            wrc(pio_pkg::LIGHT_BASE, d, {24'h0, d[7:0]});
            wrc(pio_pkg::BUTTON_AUX_A, d, d & 32'h3);
            wrc(pio_pkg::BUTTON_AUX_B, ~d, ~d & 32'h3);
            rc(pio_pkg::BUTTON_AUX_A, d & 32'h3);
            rc(pio_pkg::BUTTON_AUX_B, ~d & 32'h3);
            dip_toggles_i = 4'($random(seed));
            button_i = 2'($random(seed));
            header_c_in_i = 3'($random(seed));
            wr(pio_pkg::SWITCH_BASE, ~d);
            wr(pio_pkg::BUTTON_BASE, ~d);
            wr(pio_pkg::HDR_C_IN_BASE, ~d);
            wr(32'hff2000a0, ~d);
            rc(pio_pkg::SWITCH_BASE, {28'h0, dip_toggles_i});
            rc(pio_pkg::BUTTON_BASE, {30'h0, button_i});
            rc(pio_pkg::HDR_C_IN_BASE, {29'h0, header_c_in_i});
            rc(32'hff2000a0, 32'h0);
            rc(pio_pkg::LIGHT_BASE, {24'h0, d[7:0]});
        end
        for (int i = 0; i < 20; i++) begin
            for (int p = 0; p < 3; p++) begin
                base = (p == 0) ? pio_pkg::HDR_A_BASE : (p == 1) ? pio_pkg::HDR_B_BASE
                    : pio_pkg::HDR_C_BASE;
                m = (p == 2) ? 32'h00001fff : 32'hffffffff;
                od = $random(seed);
                dr = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : $random(seed);
                ext_a = $random(seed);
                ext_b = $random(seed);
                ext_c = 13'($random(seed));
                wr(base, od);
                wr(base + pio_pkg::DIR_OFF, dr);
                pin = (p == 0) ? ext_a : (p == 1) ? ext_b : {19'h0, ext_c};
                o = (p == 0) ? header_a_o : (p == 1) ? header_b_o : {19'h0, header_c_o};
                e = (p == 0) ? header_a_oe_o : (p == 1) ? header_b_oe_o
                    : {19'h0, header_c_oe_o};
                check("oe", e, dr & m);
                check("out", o, od & m);
                rc(base + pio_pkg::DIR_OFF, dr & m);
                rc(base, mix(pin, od, dr) & m);
                rc(base + pio_pkg::AUX_A_OFF, 32'h0);
                rc(base + pio_pkg::AUX_B_OFF, 32'h0);
            end
        end
        @(negedge clk_i);
        rst_n_i = 1'b0;
        @(negedge clk_i);
        rst_n_i = 1'b1;
        check("oe", header_a_oe_o | header_b_oe_o | {19'h0, header_c_oe_o}, 32'h0);
        rc(pio_pkg::HDR_A_BASE, ext_a);
        stop_test();
    end
endmodule

/* File: pio_pin_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Board pins seen by one header port
// ----------------------------------------
module pio_pin_model #(
    parameter int W = 32
) (
    // Block side
    input wire logic [W-1:0] out_i,
    input wire logic [W-1:0] oe_i,
    // Board side
    input wire logic [W-1:0] ext_i,
    output logic [W-1:0] pin_o
);
    // Driven bits follow the block, released bits follow the board
    assign pin_o = (out_i & oe_i) | (ext_i & ~oe_i);
endmodule

/* File: pio_pkg.sv */
package pio_pkg;

    // ----------------------------------------
    // Register addresses
    // ----------------------------------------
    localparam logic [31:0] LIGHT_BASE = 32'hff200000;
    localparam logic [31:0] SWITCH_BASE = 32'hff200040;
    localparam logic [31:0] BUTTON_BASE = 32'hff200050;
    localparam logic [31:0] BUTTON_AUX_A = 32'hff200058;
    localparam logic [31:0] BUTTON_AUX_B = 32'hff20005c;
    localparam logic [31:0] HDR_A_BASE = 32'hff200060;
    localparam logic [31:0] HDR_B_BASE = 32'hff200070;
    localparam logic [31:0] HDR_C_BASE = 32'hff200080;
    localparam logic [31:0] HDR_C_IN_BASE = 32'hff200090;
    localparam logic [31:0] DIR_OFF = 32'h00000004;
    localparam logic [31:0] AUX_A_OFF = 32'h00000008;
    localparam logic [31:0] AUX_B_OFF = 32'h0000000c;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int LIGHT_W = 8;
    localparam int SWITCH_W = 4;
    localparam int BUTTON_W = 2;
    localparam int HDR_W = 32;
    localparam int HDR_C_W = 13;
    localparam int HDR_C_IN_W = 3;
    localparam int HDR_PORTS = 2;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [LIGHT_W-1:0] LIGHT_RST = 8'h00;
    localparam logic [BUTTON_W-1:0] AUX_RST = 2'h0;
    localparam logic [HDR_W-1:0] HDR_RST = 32'h00000000;
    localparam logic [HDR_C_W-1:0] HDR_C_RST = 13'h0000;
    localparam logic [31:0] RDATA_RST = 32'h00000000;

    // ----------------------------------------
    // Block state
    // ----------------------------------------
    typedef struct packed {
        logic [LIGHT_W-1:0] light;
        logic [BUTTON_W-1:0] aux_a;
        logic [BUTTON_W-1:0] aux_b;
        logic [HDR_PORTS-1:0][HDR_W-1:0] hdr_out;
        logic [HDR_PORTS-1:0][HDR_W-1:0] hdr_dir;
        logic [HDR_C_W-1:0] c_out;
        logic [HDR_C_W-1:0] c_dir;
        logic [31:0] rdata;
        logic rvalid;
    } pio_state_s;

endpackage
